// [fnd_pkg.sv]
`default_nettype none
package fnd_pkg;
  localparam int ADDR_W = 8;
  localparam int REG_W  = 24;
  localparam int INT_W  = 19;
  localparam int FRAC_W = 24;
  localparam int NDIV_W = 20;
  localparam int ODIV_W = 6;

  localparam logic [ADDR_W-1:0] ADDR_REFDIV = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_INTDIV = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_FRAC   = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_MODE   = 8'h06;
  localparam logic [ADDR_W-1:0] ADDR_STEP   = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_OUTDIV = 8'h16;

  localparam int MODE_FRAC_EN_BIT = 11;
  localparam int MODE_BYPASS_BIT  = 7;

  localparam logic [INT_W-1:0]  NINT_MIN   = 19'h00010;
  localparam logic [INT_W-1:0]  NINT_MAX   = 19'h7FFFF;
  localparam logic [REG_W-1:0]  RST_REFDIV = 24'h000001;
  localparam logic [INT_W-1:0]  RST_INTDIV = 19'h00010;
  localparam logic [FRAC_W-1:0] RST_FRAC   = 24'h000000;
  localparam logic [REG_W-1:0]  RST_MODE   = 24'h000080;
  localparam logic [REG_W-1:0]  RST_STEP   = 24'h000000;
  localparam logic [ODIV_W-1:0] RST_OUTDIV = 6'h00;

  typedef struct packed {
    logic [REG_W-1:0]  refdiv;
    logic [INT_W-1:0]  nint;
    logic [FRAC_W-1:0] nfrac;
    logic [REG_W-1:0]  mode;
    logic [REG_W-1:0]  step;
    logic [ODIV_W-1:0] outdiv;
  } fnd_regs_s;

  localparam fnd_regs_s RST_REGS = '{RST_REFDIV, RST_INTDIV, RST_FRAC,
                                     RST_MODE, RST_STEP, RST_OUTDIV};

  typedef struct packed {
    fnd_regs_s         regs;
    fnd_regs_s         act;
    logic [REG_W-1:0]  rdata;
    logic [REG_W-1:0]  ref_cnt;
    logic              pd_tick;
    logic [FRAC_W-1:0] acc;
    logic [REG_W-1:0]  ph_cnt;
    logic [NDIV_W-1:0] ndiv;
    logic [ODIV_W-1:0] out_cnt;
    logic              out_pulse;
    logic              range_err;
  } fnd_top_state_s;

  typedef struct packed {
    logic [NDIV_W-1:0] cnt;
    logic              fb_pulse;
  } fnd_fb_state_s;
endpackage : fnd_pkg
`default_nettype wire

// [fnd_fbdiv.sv]
`default_nettype none
module fnd_fbdiv
  import fnd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              vco_edge,
  input  wire logic [NDIV_W-1:0] load_val,
  output logic                   fb_pulse,
  output logic [NDIV_W-1:0]      cnt
);
  fnd_fb_state_s s_r;
  fnd_fb_state_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.fb_pulse = 1'b0;
    if (vco_edge)
    begin
      // New divide value only taken at terminal count
      if (s_r.cnt <= NDIV_W'(1))
      begin
        s_nxt.cnt      = load_val;
        s_nxt.fb_pulse = 1'b1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt - NDIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign fb_pulse = s_r.fb_pulse;
  assign cnt      = s_r.cnt;
endmodule : fnd_fbdiv
`default_nettype wire

// [fnd_tuning.sv]
`default_nettype none
module fnd_tuning
  import fnd_pkg::*;
#(
  parameter int INT_BITS  = 19,
  parameter int FRAC_BITS = 24
)
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] REG_ADDR,
  input  wire logic [REG_W-1:0]  REG_WDATA,
  input  wire logic              REG_WE,
  input  wire logic              REG_RE,
  output logic      [REG_W-1:0]  REG_RDATA,
  input  wire logic              VCO_EDGE,
  output logic                   PD_TICK,
  output logic                   FB_PULSE,
  output logic                   OUT_PULSE,
  output logic      [NDIV_W-1:0] DIV_NOW,
  output logic                   FRAC_MODE,
  output logic                   EXACT_MODE,
  output logic                   NINT_RANGE_ERR
);
  if (INT_BITS != INT_W || FRAC_BITS != FRAC_W)
  begin : g_chk
    $error("fnd_tuning: divider widths must match the package");
  end

  fnd_top_state_s s_r;
  fnd_top_state_s s_nxt;

  function automatic logic frac_on(input logic [REG_W-1:0] mode);
    frac_on = mode[MODE_FRAC_EN_BIT] & ~mode[MODE_BYPASS_BIT];
  endfunction : frac_on

  function automatic logic [ODIV_W-1:0] k_of(input logic [ODIV_W-1:0] f);
    if (f <= ODIV_W'(1))
      k_of = ODIV_W'(1);
    else
      k_of = {f[ODIV_W-1:1], 1'b0};
  endfunction : k_of

  function automatic logic [INT_W-1:0] nint_ok(input logic [INT_W-1:0] n);
    nint_ok = (n < NINT_MIN) ? NINT_MIN : n;
  endfunction : nint_ok

  always_comb
  begin
    logic [FRAC_W:0]   sum;
    logic              carry;
    logic [REG_W-1:0]  rdiv;
    logic [REG_W-1:0]  stp;
    logic              fmode;
    logic              exact;
    logic [ODIV_W-1:0] k;
    fnd_regs_s         nc;
    sum   = '0;
    carry = 1'b0;
    rdiv  = '0;
    stp   = '0;
    fmode = 1'b0;
    exact = 1'b0;
    k     = '0;
    nc    = '0;
    s_nxt = s_r;
    s_nxt.pd_tick   = 1'b0;
    s_nxt.out_pulse = 1'b0;

    // Register writes
    if (REG_WE)
    begin
      case (REG_ADDR)
        ADDR_REFDIV: s_nxt.regs.refdiv = REG_WDATA;
        ADDR_INTDIV: s_nxt.regs.nint   = REG_WDATA[INT_W-1:0];
        ADDR_FRAC:   s_nxt.regs.nfrac  = REG_WDATA[FRAC_W-1:0];
        ADDR_MODE:   s_nxt.regs.mode   = REG_WDATA;
        ADDR_STEP:   s_nxt.regs.step   = REG_WDATA;
        ADDR_OUTDIV: s_nxt.regs.outdiv = REG_WDATA[ODIV_W-1:0];
        default:     ;
      endcase
    end

    // Register reads
    if (REG_RE)
    begin
      case (REG_ADDR)
        ADDR_REFDIV: s_nxt.rdata = s_r.regs.refdiv;
        ADDR_INTDIV: s_nxt.rdata = REG_W'(s_r.regs.nint);
        ADDR_FRAC:   s_nxt.rdata = s_r.regs.nfrac;
        ADDR_MODE:   s_nxt.rdata = s_r.regs.mode;
        ADDR_STEP:   s_nxt.rdata = s_r.regs.step;
        ADDR_OUTDIV: s_nxt.rdata = REG_W'(s_r.regs.outdiv);
        default:     s_nxt.rdata = '0;
      endcase
    end

    // Reference divider, a zero ratio acts as one
    rdiv = (s_r.act.refdiv == '0) ? REG_W'(1) : s_r.act.refdiv;
    if (s_r.ref_cnt >= rdiv - REG_W'(1))
    begin
      s_nxt.ref_cnt = '0;
      s_nxt.pd_tick = 1'b1;
    end
    else
    begin
      s_nxt.ref_cnt = s_r.ref_cnt + REG_W'(1);
    end

    // Comparison cycle: take new configuration and step the modulator
    nc    = s_r.regs;
    fmode = frac_on(nc.mode);
    exact = fmode && (nc.step != '0);
    stp   = nc.step;
    if (s_nxt.pd_tick)
    begin
      s_nxt.act = nc;
      if (!fmode)
      begin
        s_nxt.acc    = '0;
        s_nxt.ph_cnt = '0;
      end
      else if (nc.nfrac != s_r.act.nfrac || nc.step != s_r.act.step)
      begin
        s_nxt.acc    = '0;
        s_nxt.ph_cnt = '0;
        sum   = {1'b0, nc.nfrac};
        carry = sum[FRAC_W];
        s_nxt.acc = sum[FRAC_W-1:0];
      end
      else
      begin
        sum   = {1'b0, s_r.acc} + {1'b0, nc.nfrac};
        carry = sum[FRAC_W];
        s_nxt.acc = sum[FRAC_W-1:0];
      end
      if (exact)
      begin
        // Restart the pattern every step count, keeping 2^24 modulus
        if (s_nxt.ph_cnt >= stp - REG_W'(1))
        begin
          s_nxt.acc    = '0;
          s_nxt.ph_cnt = '0;
        end
        else
        begin
          s_nxt.ph_cnt = s_nxt.ph_cnt + REG_W'(1);
        end
      end
      s_nxt.ndiv = NDIV_W'(nint_ok(nc.nint)) + NDIV_W'(carry);
      s_nxt.range_err = (nc.nint < NINT_MIN);
    end

    // Output divider
    k = k_of(s_r.act.outdiv);
    if (VCO_EDGE)
    begin
      if (s_r.out_cnt >= k - ODIV_W'(1))
      begin
        s_nxt.out_cnt   = '0;
        s_nxt.out_pulse = 1'b1;
      end
      else
      begin
        s_nxt.out_cnt = s_r.out_cnt + ODIV_W'(1);
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s_r           <= '0;
      s_r.regs      <= RST_REGS;
      s_r.act       <= RST_REGS;
      s_r.ndiv      <= NDIV_W'(RST_INTDIV);
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  fnd_fbdiv u_fbdiv (
    .clk      (CLK),
    .rst_n    (RST_N),
    .vco_edge (VCO_EDGE),
    .load_val (s_r.ndiv),
    .fb_pulse (FB_PULSE),
    .cnt      ()
  );

  assign REG_RDATA      = s_r.rdata;
  assign PD_TICK        = s_r.pd_tick;
  assign OUT_PULSE      = s_r.out_pulse;
  assign DIV_NOW        = s_r.ndiv;
  assign FRAC_MODE      = frac_on(s_r.act.mode);
  assign EXACT_MODE     = frac_on(s_r.act.mode) && (s_r.act.step != '0);
  assign NINT_RANGE_ERR = s_r.range_err;
endmodule : fnd_tuning
`default_nettype wire

// [fnd_tuning_sva.sv]
`default_nettype none
module fnd_tuning_sva
  import fnd_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RST_N,
  input wire logic [ADDR_W-1:0] REG_ADDR,
  input wire logic              REG_RE,
  input wire logic [REG_W-1:0]  REG_RDATA,
  input wire logic              VCO_EDGE,
  input wire logic              PD_TICK,
  input wire logic              FB_PULSE,
  input wire logic              OUT_PULSE,
  input wire logic [NDIV_W-1:0] DIV_NOW,
  input wire logic              FRAC_MODE,
  input wire logic              EXACT_MODE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_unmap;
    REG_RE && REG_ADDR == 8'h05 |=> REG_RDATA == 24'h000000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_int_rd;
    REG_RE && REG_ADDR == ADDR_INTDIV |=> REG_RDATA[23:19] == 5'h00;
  endproperty
  a_int_rd: assert property (p_int_rd) else $error("int width");
  property p_rd_hold;
    !REG_RE |=> $stable(REG_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_div_min;
    DIV_NOW >= 20'h00010;
  endproperty
  a_div_min: assert property (p_div_min) else $error("divide low");
  property p_exact;
    EXACT_MODE |-> FRAC_MODE;
  endproperty
  a_exact: assert property (p_exact) else $error("exact mode");
  property p_mode_hold;
    $changed(FRAC_MODE) || $changed(EXACT_MODE) |-> PD_TICK;
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode glitch");
  property p_div_hold;
    $changed(DIV_NOW) |-> PD_TICK;
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divide glitch");
  property p_fb_gap;
    FB_PULSE |=> !FB_PULSE [*8];
  endproperty
  a_fb_gap: assert property (p_fb_gap) else $error("feedback gap");
  property p_fb_src;
    FB_PULSE || OUT_PULSE |-> $past(VCO_EDGE);
  endproperty
  a_fb_src: assert property (p_fb_src) else $error("pulse source");
  c_exact: cover property (PD_TICK && EXACT_MODE);
  c_fb: cover property (FB_PULSE);
  c_out: cover property (OUT_PULSE);
endmodule : fnd_tuning_sva
bind fnd_tuning fnd_tuning_sva fnd_tuning_sva_i (.*);
`default_nettype wire

// [fnd_tuning_test.sv]
`default_nettype none
module fnd_tuning_test;
  import fnd_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk = 0;
  logic              rst_n = 0;
  logic              we = 0;
  logic              re = 0;
  logic              ve = 0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [REG_W-1:0]  wd = 24'h000000;
  logic [REG_W-1:0]  rd;
  logic [REG_W-1:0]  v;
  logic [NDIV_W-1:0] dn;
  logic              pd, fb, op, fm, em, ne;
  int                fail_count = 0, compares = 0, cyc = 0;
  int                seed = 32'h0000D4BF;
  int                s, t, o, e, f;
  int                ok[5] = '{1, 2, 6, 6, 62};
  logic [REG_W-1:0]  ov[5] = '{24'h0, 24'h2, 24'h6, 24'h7, 24'h3E};
  logic [REG_W-1:0]  mv[4] = '{24'h0, 24'h80, 24'h880, 24'h800};
  logic [ADDR_W-1:0] ra[6] = '{ADDR_REFDIV, ADDR_INTDIV, ADDR_FRAC,
                               ADDR_MODE, ADDR_STEP, ADDR_OUTDIV};
  logic [REG_W-1:0]  rv[6] = '{24'h1, 24'h10, 24'h0, 24'h80, 24'h0, 24'h0};
  logic [REG_W-1:0]  rm[6] = '{24'hFFFFFF, 24'h7FFFF, 24'hFFFFFF,
                               24'hFFFFFF, 24'hFFFFFF, 24'h3F};
  fnd_tuning fnd_tuning_i (.CLK(clk), .RST_N(rst_n), .REG_ADDR(addr),
    .REG_WDATA(wd), .REG_WE(we), .REG_RE(re), .REG_RDATA(rd),
    .VCO_EDGE(ve), .PD_TICK(pd), .FB_PULSE(fb), .OUT_PULSE(op),
    .DIV_NOW(dn), .FRAC_MODE(fm), .EXACT_MODE(em), .NINT_RANGE_ERR(ne));
  always #2 clk = ~clk;
  task automatic conclude();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk)
    if (++cyc > 20000)
    begin
      fail_count++;
      conclude();
    end
  task automatic chk(string n, logic [REG_W-1:0] x, logic [REG_W-1:0] y);
    compares++;
    if (x !== y)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask : chk
  function automatic logic near(int a, int b, int w);
    return (a - b <= w) && (b - a <= w);
  endfunction : near
  task automatic wr(logic [ADDR_W-1:0] a, logic [REG_W-1:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    we = 1;
    @(negedge clk);
    we = 0;
  endtask : wr
  task automatic rdr(logic [ADDR_W-1:0] a);
    @(negedge clk);
    addr = a;
    re = 1;
    @(negedge clk);
    re = 0;
    v = rd;
  endtask : rdr
  // Counts ticks, carries above 20, pulses and VCO edges
  task automatic run(int n);
    {s, t, o, e, f} = '0;
    repeat (n)
    begin
      @(negedge clk);
      if (pd === 1'b1)
      begin
        t++;
        s += int'(dn) - 20;
      end
      o += int'(op === 1'b1);
      f += int'(fb === 1'b1);
      e += int'(ve);
      ve = 1'($random(seed));
    end
  endtask : run
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    foreach (ra[i])
    begin
      rdr(ra[i]);
      chk("reset", rv[i], v);
      wd = $random(seed);
      wr(ra[i], (i == 0) ? (wd & 24'h3) : wd);
      rdr(ra[i]);
      chk("readback", wd & rm[i] & ((i == 0) ? 24'h3 : 24'hFFFFFF), v);
    end
    wr(8'h05, 24'h123456);
    rdr(8'h05);
    chk("unmapped", 24'h0, v);
    wr(ADDR_REFDIV, 24'h5);
    run(10);
    run(50);
    chk("ticks", 24'd10, 24'(t));
    wr(ADDR_REFDIV, 24'h1);
    wr(ADDR_INTDIV, 24'd20);
    wr(ADDR_FRAC, 24'h400000);
    wr(ADDR_STEP, 24'h0);
    wr(ADDR_MODE, 24'h800);
    run(20);
    run(64);
    chk("quarter", 24'd16, 24'(s));
    chk("exact", 24'h0, 24'(em));
    wr(ADDR_FRAC, 24'hFFFFFF);
    wr(ADDR_STEP, 24'h3);
    run(20);
    run(30);
    chk("exactsum", 24'd20, 24'(s));
    chk("exact", 24'h1, 24'(em));
    wr(ADDR_STEP, 24'h0);
    foreach (mv[i])
    begin
      wr(ADDR_MODE, mv[i]);
      run(20);
      run(30);
      chk("fracmode", 24'(i == 3), 24'(fm));
      if (i < 3) chk("carries", 24'h0, 24'(s));
    end
    wr(ADDR_MODE, 24'h80);
    wr(ADDR_INTDIV, 24'h5);
    run(10);
    chk("clamp", 24'h10, 24'(dn));
    chk("rangeerr", 24'h1, 24'(ne));
    wr(ADDR_INTDIV, 24'h7FFFF);
    run(10);
    chk("maxdiv", 24'h7FFFF, 24'(dn));
    chk("rangeerr", 24'h0, 24'(ne));
    // Mid-run reset after the largest divide returns DIV_NOW, the range flag and the mode register to reset values
    @(negedge clk);
    rst_n = 0;
    ve = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    chk("rstdiv", 24'h10, 24'(dn));
    chk("rstflag", 24'h0, 24'(ne));
    rdr(ADDR_MODE);
    chk("rstmode", 24'h80, v);
    wr(ADDR_INTDIV, 24'd20);
    foreach (ov[i])
    begin
      wr(ADDR_OUTDIV, ov[i]);
      run(60);
      run(744);
      chk("outdiv", 24'h1, 24'(near(o * ok[i], e, 2 * ok[i])));
      chk("fbdiv", 24'h1, 24'(near(f * 20, e, 40)));
    end
    conclude();
  end
endmodule : fnd_tuning_test
`default_nettype wire
